// ---- rtl/pmpm_partition_map.v ----
// program memory partition map, protection checks and indirect read path
// How it works
// - pointer high byte bit 7 set sends indirect reads to program memory
// - indirect move to w returns only the low byte of the word
// - indirect writes aimed at program memory are dropped
// - indirect program memory reads take one extra instruction cycle
// - layout comes from boot enable, boot size and storage enable settings
// - both enables high: all user flash is application region
// - boot enabled: boot region from zero to selected end address
// - storage enabled: last 128 words form the storage region
// - no execution from the storage region when it is enabled
// - storage region uses the same nonvolatile path as other flash
// - each region has a write protect; blocked writes set write error
// - fetch outside valid area resets and clears violation flag
// - size field codes end address; codes 0 to 3 clamp to half memory
// - size field writable only while boot is disabled, else bulk erase
// - write protection stays on until a bulk erase or a reset
// - addresses above the implemented size wrap around
`include "pmpm_regs.vh"
module pmpm_partition_map (
    input  wire                    clk,              // core instruction clock
    input  wire                    rst,              // synchronous reset, high
    input  wire                    ce,               // clock enable
    input  wire                    cfg_wr,           // configuration write strobe
    input  wire [2:0]              cfg_boot_size,    // new boot size field
    input  wire                    cfg_boot_en_n,    // new boot enable, low active
    input  wire                    cfg_saf_en_n,     // new storage enable, low active
    input  wire [4:0]              cfg_wp_n,         // new protects app,boot,cfg,ee,saf
    input  wire                    bulk_erase,       // bulk erase pulse
    input  wire                    fetch_valid,      // instruction fetch strobe
    input  wire [`PMPM_ADDR_W-1:0] fetch_addr,       // fetch address
    input  wire                    ind_valid,        // indirect access strobe
    input  wire                    ind_write,        // indirect access is a write
    input  wire [7:0]              ind_ptr_high,     // pointer high byte
    input  wire [7:0]              ind_ptr_low,      // pointer low byte
    input  wire [13:0]             flash_rdata,      // flash word from array
    input  wire                    nvm_wr_req,       // nonvolatile write request
    input  wire [`PMPM_ADDR_W-1:0] nvm_wr_addr,      // nonvolatile write address
    input  wire                    viol_flag_clr,    // software sets violation flag
    output reg                     ind_to_pm,        // indirect read targets flash
    output reg                     ind_data_wr,      // pass write on to data memory
    output reg  [`PMPM_ADDR_W-1:0] flash_raddr,      // flash read address
    output reg                     flash_rd,         // flash read strobe
    output reg  [7:0]              w_rdata,          // byte returned to w
    output reg                     w_rvalid,         // returned byte valid
    output reg                     core_stall,       // extra instruction cycle
    output reg                     nvm_wr_ok,        // write allowed to flash
    output reg                     write_error_flag, // blocked write seen
    output reg                     exec_viol_reset,  // violation reset pulse
    output reg                     exec_violation_flag_n, // violation flag, low active
    output reg  [2:0]              boot_size_reg,    // active boot size
    output reg                     boot_en_n_reg,    // active boot enable
    output reg                     saf_en_n_reg,     // active storage enable
    output reg  [4:0]              wp_n_reg          // active protects, low active
);
    localparam ST_IDLE = 2'b01;
    localparam ST_WAIT = 2'b10;

    reg [1:0] state_reg;
    reg [1:0] state_next;

    wire [`PMPM_IMPL_W-1:0] f_wrap = fetch_addr[`PMPM_IMPL_W-1:0];
    wire [`PMPM_IMPL_W-1:0] w_wrap = nvm_wr_addr[`PMPM_IMPL_W-1:0];
    wire [`PMPM_ADDR_W-1:0] ind_addr = {ind_ptr_high[6:0], ind_ptr_low};
    wire ind_pm = ind_ptr_high[`PMPM_PTR_PM_BIT];

    wire f_boot, f_app, f_saf;
    wire w_boot, w_app, w_saf;

    pmpm_region_decode u_fetch_dec (
        .addr      (f_wrap),
        .boot_en_n (boot_en_n_reg),
        .boot_size (boot_size_reg),
        .saf_en_n  (saf_en_n_reg),
        .in_boot   (f_boot),
        .in_app    (f_app),
        .in_saf    (f_saf)
    );

    pmpm_region_decode u_write_dec (
        .addr      (w_wrap),
        .boot_en_n (boot_en_n_reg),
        .boot_size (boot_size_reg),
        .saf_en_n  (saf_en_n_reg),
        .in_boot   (w_boot),
        .in_app    (w_app),
        .in_saf    (w_saf)
    );

    // nonvolatile write target class and the protect it selects
    wire w_is_ee  = (nvm_wr_addr >= `PMPM_EEPROM_BASE);
    wire w_is_cfg = !w_is_ee && nvm_wr_addr[14];
    reg  w_protected;
    always @* begin
        if (w_is_ee)
            w_protected = !wp_n_reg[1];
        else if (w_is_cfg)
            w_protected = !wp_n_reg[2];
        else if (w_saf)
            w_protected = !wp_n_reg[0];
        else if (w_boot)
            w_protected = !wp_n_reg[3];
        else
            w_protected = !wp_n_reg[4] && w_app;
    end

    // fetch outside application or boot region, or inside storage
    wire fetch_bad = fetch_valid && (f_saf || !(f_app || f_boot));

    // flash read request seen by the idle sequencer
    wire ind_rd_start = ind_valid && ind_pm && !ind_write;

    // indirect read sequencer, next state
    always @* begin
        case (state_reg)
            ST_IDLE: begin
                if (ind_rd_start) begin
                    state_next = ST_WAIT;
                end else begin
                    state_next = ST_IDLE;
                end
            end
            ST_WAIT: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // sequencer state
    always @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // configuration settings, bulk erase wins over a write
    always @(posedge clk) begin
        if (rst) begin
            boot_size_reg <= 3'h7;
            boot_en_n_reg <= 1'b1;
            saf_en_n_reg  <= 1'b1;
            wp_n_reg      <= 5'h1f;
        end else if (ce) begin
            if (bulk_erase) begin
                boot_size_reg <= 3'h7;
                boot_en_n_reg <= 1'b1;
                saf_en_n_reg  <= 1'b1;
                wp_n_reg      <= 5'h1f;
            end else if (cfg_wr) begin
                if (boot_en_n_reg) begin
                    boot_size_reg <= cfg_boot_size;
                end
                boot_en_n_reg <= boot_en_n_reg & cfg_boot_en_n;
                saf_en_n_reg  <= cfg_saf_en_n;
                wp_n_reg      <= wp_n_reg & cfg_wp_n;
            end
        end
    end

    // nonvolatile write gate, error flag sticky until reset
    always @(posedge clk) begin
        if (rst) begin
            nvm_wr_ok        <= 1'b0;
            write_error_flag <= 1'b0;
        end else if (ce) begin
            nvm_wr_ok <= nvm_wr_req && !w_protected;
            if (nvm_wr_req && w_protected) begin
                write_error_flag <= 1'b1;
            end
        end
    end

    // execution violation, a new violation wins over the clear
    always @(posedge clk) begin
        if (rst) begin
            exec_viol_reset       <= 1'b0;
            exec_violation_flag_n <= 1'b1;
        end else if (ce) begin
            exec_viol_reset <= fetch_bad;
            if (fetch_bad) begin
                exec_violation_flag_n <= 1'b0;
            end else if (viol_flag_clr) begin
                exec_violation_flag_n <= 1'b1;
            end
        end
    end

    // indirect path outputs
    always @(posedge clk) begin
        if (rst) begin
            ind_to_pm   <= 1'b0;
            ind_data_wr <= 1'b0;
            flash_raddr <= {`PMPM_ADDR_W{1'b0}};
            flash_rd    <= 1'b0;
            w_rdata     <= 8'h00;
            w_rvalid    <= 1'b0;
            core_stall  <= 1'b0;
        end else if (ce) begin
            flash_rd    <= 1'b0;
            w_rvalid    <= 1'b0;
            ind_data_wr <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (ind_rd_start) begin
                        ind_to_pm   <= 1'b1;
                        flash_raddr <= {2'b00, ind_addr[`PMPM_IMPL_W-1:0]};
                        flash_rd    <= 1'b1;
                        core_stall  <= 1'b1;
                    end else begin
                        ind_to_pm   <= 1'b0;
                        ind_data_wr <= ind_valid && ind_write && !ind_pm;
                    end
                end
                ST_WAIT: begin
                    w_rdata    <= flash_rdata[7:0];
                    w_rvalid   <= 1'b1;
                    core_stall <= 1'b0;
                    ind_to_pm  <= 1'b0;
                end
                default: begin
                    core_stall <= 1'b0;
                    ind_to_pm  <= 1'b0;
                end
            endcase
        end
    end
endmodule // pmpm_partition_map

// ---- rtl/pmpm_region_decode.v ----
// combinational region decoder for one program address
`include "pmpm_regs.vh"
module pmpm_region_decode (
    input  wire [`PMPM_IMPL_W-1:0] addr,        // wrapped address
    input  wire                    boot_en_n,   // boot region enable, low active
    input  wire [2:0]              boot_size,   // boot size field
    input  wire                    saf_en_n,    // storage region enable, low active
    output wire                    in_boot,     // address in boot region
    output wire                    in_app,      // address in application region
    output wire                    in_saf       // address in storage region
);
    reg  [`PMPM_IMPL_W-1:0] boot_end;
    wire [`PMPM_IMPL_W-1:0] saf_start = `PMPM_LAST_ADDR - `PMPM_SAF_SPAN;

    always @* begin
        case (boot_size)
            3'h7:    boot_end = `PMPM_BOOT_END_111;
            3'h6:    boot_end = `PMPM_BOOT_END_110;
            3'h5:    boot_end = `PMPM_BOOT_END_101;
            3'h4:    boot_end = `PMPM_BOOT_END_100;
            default: boot_end = `PMPM_HALF_LAST;
        endcase
    end

    assign in_boot = !boot_en_n && (addr <= boot_end);
    assign in_saf  = !saf_en_n && (addr >= saf_start);
    assign in_app  = !in_boot && !in_saf;
endmodule // pmpm_region_decode

// ---- rtl/pmpm_regs.vh ----
// constants for the program memory partition map
`ifndef PMPM_REGS_VH
`define PMPM_REGS_VH
`define PMPM_ADDR_W        15
`define PMPM_IMPL_W        13
`define PMPM_LAST_ADDR     13'h1fff
`define PMPM_HALF_LAST     13'h0fff
`define PMPM_SAF_SPAN      13'h007f
`define PMPM_BOOT_END_111  13'h01ff
`define PMPM_BOOT_END_110  13'h03ff
`define PMPM_BOOT_END_101  13'h07ff
`define PMPM_BOOT_END_100  13'h0fff
`define PMPM_PTR_PM_BIT    7
`define PMPM_CFG_RST       8'hff
`define PMPM_CFG_STORAGE_REGION_ENABLE_N     4
`define PMPM_CFG_BOOT_REGION_ENABLE_N      3
`define PMPM_EEPROM_BASE   15'h7000
`define PMPM_CONFIG_BASE   15'h0007
`define PMPM_EXTRA_CYCLES  1
`endif

// ---- tb/pmpm_flash_model.sv ----
// flash array model answering the read strobe
module pmpm_flash_model (
    input  wire logic        clk,         // core clock
    input  wire logic        flash_rd,    // read strobe
    input  wire logic [14:0] flash_raddr, // word address
    output wire logic [13:0] flash_rdata  // word, inverted last value when idle
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] last_reg = 14'h0000;
    wire  [13:0] word = {flash_raddr[5:0], flash_raddr[7:0] ^ 8'h3c};
    assign flash_rdata = flash_rd ? word : ~last_reg;
    always @(posedge clk) if (flash_rd) last_reg <= word;
endmodule // pmpm_flash_model

// ---- tb/pmpm_partition_map_asserts.sv ----
// port assertions for the partition map
module pmpm_partition_map_asserts (
    input wire logic        clk, rst, ce, ind_valid, ind_write, // core side
    input wire logic        fetch_valid, nvm_wr_req, bulk_erase, // requests
    input wire logic        flash_rd, w_rvalid, core_stall, ind_to_pm, ind_data_wr, // indirect path
    input wire logic        nvm_wr_ok, write_error_flag, exec_viol_reset, // results
    input wire logic        exec_violation_flag_n, boot_en_n_reg, saf_en_n_reg, // flags
    input wire logic [7:0]  ind_ptr_high, w_rdata, // bytes
    input wire logic [13:0] flash_rdata, // flash word
    input wire logic [14:0] fetch_addr, nvm_wr_addr, flash_raddr, // addresses
    input wire logic [2:0]  boot_size_reg, // boot size
    input wire logic [4:0]  wp_n_reg // protects
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ind_read_a: assert property (
        ce && ind_valid && !ind_write && ind_ptr_high[7] && !core_stall
        |=> flash_rd && core_stall && ind_to_pm) else $error("indirect read not started");
    low_byte_a: assert property (ce && flash_rd |-> flash_raddr[14:13] == 2'h0
        ##1 w_rvalid && w_rdata == 8'($past(flash_rdata))) else $error("bad read byte");
    write_drop_a: assert property (
        ce && ind_valid && ind_write && ind_ptr_high[7] && !core_stall
        |=> !ind_data_wr && !flash_rd) else $error("flash write not dropped");
    one_stall_a: assert property (ce && core_stall |=> !core_stall)
        else $error("stall too long");
    saf_fetch_a: assert property (
        ce && fetch_valid && !saf_en_n_reg && fetch_addr[12:0] >= 13'h1f80
        |=> exec_viol_reset && !exec_violation_flag_n) else $error("storage fetch ran");
    app_fetch_a: assert property (
        ce && fetch_valid && (saf_en_n_reg || fetch_addr[12:0] < 13'h1f80)
        |=> !exec_viol_reset) else $error("false violation");
    boot_prot_a: assert property (
        ce && nvm_wr_req && !boot_en_n_reg && !wp_n_reg[3] && nvm_wr_addr < 15'h0200
        |=> write_error_flag && !nvm_wr_ok) else $error("boot write not blocked");
    prot_keep_a: assert property (ce && !bulk_erase
        |=> (wp_n_reg & ~$past(wp_n_reg)) == 5'h00) else $error("protect released");
    size_lock_a: assert property (ce && !bulk_erase && !boot_en_n_reg
        |=> $stable(boot_size_reg)) else $error("boot size changed");
endmodule // pmpm_partition_map_asserts
bind pmpm_partition_map pmpm_partition_map_asserts u_pmpm_partition_map_asserts (.clk, .rst, .ce,
    .ind_valid, .ind_write, .fetch_valid, .nvm_wr_req, .bulk_erase, .flash_rd, .w_rvalid,
    .core_stall, .ind_to_pm, .ind_data_wr, .nvm_wr_ok, .write_error_flag, .exec_viol_reset,
    .exec_violation_flag_n, .boot_en_n_reg, .saf_en_n_reg, .ind_ptr_high, .w_rdata,
    .flash_rdata, .fetch_addr, .nvm_wr_addr, .flash_raddr, .boot_size_reg, .wp_n_reg);

// ---- tb/pmpm_partition_map_bench.sv ----
// self-checking bench for the program memory partition map
module pmpm_partition_map_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, ce = 1, cfg_wr = 0, cfg_boot_en_n = 1, cfg_saf_en_n = 1;
    logic bulk_erase = 0, fetch_valid = 0, ind_valid = 0, ind_write = 0, nvm_wr_req = 0;
    logic viol_flag_clr = 0, v, p, ew = 0, bex = 1, sfx = 1;
    logic [2:0] cfg_boot_size = 3'h7, szx = 3'h7, boot_size_reg;
    logic [4:0] cfg_wp_n = 5'h1f, wpx = 5'h1f, wp_n_reg;
    logic [7:0] ind_ptr_high = 8'h00, ind_ptr_low = 8'h00, w_rdata, snap;
    logic [14:0] fetch_addr = 15'h0000, nvm_wr_addr = 15'h0000, flash_raddr, a;
    logic [13:0] flash_rdata;
    logic ind_to_pm, ind_data_wr, flash_rd, w_rvalid, core_stall, nvm_wr_ok, write_error_flag;
    logic exec_viol_reset, exec_violation_flag_n, boot_en_n_reg, saf_en_n_reg;
    int err_total = 0, num_checks = 0, i, k;
    always #2 clk = ~clk;
    pmpm_partition_map u_pmpm_partition_map (.clk, .rst, .ce, .cfg_wr, .cfg_boot_size,
        .cfg_boot_en_n, .cfg_saf_en_n, .cfg_wp_n, .bulk_erase, .fetch_valid, .fetch_addr,
        .ind_valid, .ind_write, .ind_ptr_high, .ind_ptr_low, .flash_rdata, .nvm_wr_req,
        .nvm_wr_addr, .viol_flag_clr, .ind_to_pm, .ind_data_wr, .flash_raddr, .flash_rd,
        .w_rdata, .w_rvalid, .core_stall, .nvm_wr_ok, .write_error_flag, .exec_viol_reset,
        .exec_violation_flag_n, .boot_size_reg, .boot_en_n_reg, .saf_en_n_reg, .wp_n_reg);
    pmpm_flash_model u_pmpm_flash_model (.clk, .flash_rd, .flash_raddr, .flash_rdata);
    task automatic tick; @(posedge clk); #1; endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic [12:0] boot_end(input logic [2:0] s);
        return (s == 3'h7) ? 13'h01ff : (s == 3'h6) ? 13'h03ff : (s == 3'h5) ? 13'h07ff : 13'h0fff;
    endfunction
    function automatic logic prot(input logic [14:0] w);
        if (w >= 15'h7000) return !wpx[1];
        if (w[14]) return !wpx[2];
        if (!bex && w[12:0] <= boot_end(szx)) return !wpx[3];
        if (!sfx && w[12:0] >= 13'h1f80) return !wpx[0];
        return !wpx[4];
    endfunction
    task automatic cfg(input logic [2:0] s, input logic be, se, input logic [4:0] wp, input logic bulk);
        {cfg_boot_size, cfg_boot_en_n, cfg_saf_en_n, cfg_wp_n} = {s, be, se, wp};
        cfg_wr = !bulk;
        bulk_erase = bulk;
        tick;
        {cfg_wr, bulk_erase} = 2'b00;
        if (bex || bulk) szx = bulk ? 3'h7 : s;
        {bex, sfx, wpx} = bulk ? 7'h7f : {bex & be, se, wpx & wp};
        check({boot_size_reg, boot_en_n_reg, saf_en_n_reg, wp_n_reg}, {szx, bex, sfx, wpx});
    endtask
    initial begin
        void'($urandom(32'h0f764773));
        repeat (4) tick;
        rst = 0;
        check({boot_size_reg, boot_en_n_reg, saf_en_n_reg, wp_n_reg, write_error_flag,
               exec_violation_flag_n}, 16'h0ffd);
        for (i = 0; i < 24; i++) begin
            {ind_ptr_high, ind_ptr_low, ind_write} = 17'($urandom);
            ind_valid = 1;
            tick;
            ind_valid = 0;
            v = ind_ptr_high[7] & !ind_write;
            check({ind_to_pm, flash_rd, core_stall, ind_data_wr},
                  {v, v, v, !ind_ptr_high[7] & ind_write});
            if (v) check(flash_raddr, {2'h0, ind_ptr_high[4:0], ind_ptr_low});
            tick;
            check({w_rvalid, core_stall, w_rdata}, {v, 1'b0, v ? ind_ptr_low ^ 8'h3c : w_rdata});
        end
        $display("indirect test done");
        for (i = 0; i < 40; i++) begin
            if (i == 20) cfg(3'h7, 1'b1, 1'b0, 5'h1f, 1'b0);
            a = 15'($urandom);
            if (i[1]) a[12:7] = 6'h3f;
            fetch_addr = a;
            fetch_valid = 1;
            viol_flag_clr = i[0];
            tick;
            fetch_valid = 0;
            viol_flag_clr = 0;
            v = !sfx && a[12:0] >= 13'h1f80;
            check({exec_viol_reset, exec_violation_flag_n}, {v, !v});
            viol_flag_clr = 1;
            tick;
            viol_flag_clr = 0;
            check({exec_viol_reset, exec_violation_flag_n}, 2'b01);
        end
        $display("fetch test done");
        for (k = 0; k < 8; k++) begin
            cfg(3'h0, 1'b1, 1'b1, 5'h1f, 1'b1);
            cfg(3'(k), 1'b0, 1'($urandom), {1'($urandom), ~k[2], 3'($urandom)}, 1'b0);
            cfg(3'(~k), 1'b1, sfx, 5'h1f, 1'b0);
            for (i = 0; i < 12; i++) begin
                a = 15'($urandom);
                if (i < 4) a = {2'h0, i[1] ? 13'h1f7f + 13'(i[0]) : boot_end(szx) + 13'(i[0])};
                nvm_wr_addr = a;
                nvm_wr_req = 1;
                tick;
                nvm_wr_req = 0;
                p = prot(a);
                ew = ew | p;
                check({nvm_wr_ok, write_error_flag}, {!p, ew});
            end
        end
        $display("write protect test done");
        snap = {nvm_wr_ok, write_error_flag, exec_violation_flag_n, flash_rd, core_stall,
                w_rvalid, ind_to_pm, exec_viol_reset};
        ce = 0;
        {ind_ptr_high, ind_write, ind_valid} = {8'h80, 1'b0, 1'b1};
        {fetch_addr, fetch_valid, nvm_wr_req} = {15'h1fff, 1'b1, 1'b1};
        repeat (3) tick;
        check({nvm_wr_ok, write_error_flag, exec_violation_flag_n, flash_rd, core_stall,
               w_rvalid, ind_to_pm, exec_viol_reset}, snap);
        {ind_valid, fetch_valid, nvm_wr_req} = 3'b000;
        ce = 1;
        tick;
        $display("clock enable test done");
        report_and_stop;
    end
    initial begin
        #20000;
        err_total++;
        report_and_stop;
    end
endmodule // pmpm_partition_map_bench
